// >>> hw/pcssr_status_regs.sv
// Coding sublayer status register bank behind an AXI4-Lite slave.
// Summary of operation
// RULE1: Status bit 11 latches high when transmit idle seen; cleared by software.
// RULE2: Status bit 10 latches high when receive idle seen; cleared by software.
// RULE3: Status bit 9 shows live transmit low-power idle, read-only.
// RULE4: Status bit 8 shows live receive low-power idle, read-only.
// RULE5: Status bit 7 shows live fault condition, read-only.
// RULE6: Second bit 10 live link; first bit 2 latches low on link down.
// RULE7: Second bit 9 shows live high error rate, read-only.
// RULE8: Second bit 8 shows live block lock, read-only.
// RULE9: Second bit 7 latches high on high error rate until cleared.
// RULE10: Second bit 6 latches low on block lock loss until restored.
// RULE11: Second bits 5 to 0 hold a six-bit error event counter.
// RULE12: Offsets carry leading nibble 3 for MMD space; address drops it.
// RULE13: Zero write clears latches; a condition still present wins immediately.
// RULE14: Reserved bits read zero and ignore writes.
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
module pcssr_status_regs
    import pcssr_pkg::*;
#(
    parameter int unsigned ERR_CNT_W = PCSSR_ERR_CNT_W
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address.
    input wire logic [PCSSR_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data.
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address.
    input wire logic [PCSSR_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data.
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Coding sublayer conditions, asynchronous to aclk.
    input wire logic tx_idle_live,
    input wire logic rx_idle_live,
    input wire logic fault_live,
    input wire logic rx_link_up,
    input wire logic high_error_rate_live,
    input wire logic rx_block_aligned,
    input wire logic error_event,
    // Interrupt.
    output logic irq
);
    localparam int unsigned NSYNC = 7;

    typedef struct packed {
        logic aw_held;
        logic awready;
        logic wready;
        logic arready;
        logic [11:0] aw_idx;
        logic w_held;
        logic [15:0] w_data;
        logic w_low_en;
        logic w_high_en;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [15:0] rdata;
        logic [1:0] rresp;
        logic tx_idle_seen_latched;
        logic rx_idle_seen_latched;
        logic rx_link_up_latched_low;
        logic high_error_rate_latched;
        logic rx_block_aligned_latched_low;
        logic [ERR_CNT_W-1:0] err_count;
        logic err_evt_prev;
        logic [PCSSR_IRQ_W-1:0] irq_status;
        logic [PCSSR_IRQ_W-1:0] irq_mask;
        logic irq;
    } pcssr_state_t;

    pcssr_state_t state;
    pcssr_state_t next_state;

    logic [NSYNC-1:0] sync_q;
    logic s_tx_idle;
    logic s_rx_idle;
    logic s_fault;
    logic s_link;
    logic s_high_err;
    logic s_aligned;
    logic s_err_evt;
    logic [15:0] status_word;
    logic [15:0] status2_word;

    pcssr_sync #(
        .WIDTH(NSYNC)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in({error_event, rx_block_aligned, high_error_rate_live, rx_link_up,
            fault_live, rx_idle_live, tx_idle_live}),
        .sync_out(sync_q)
    );

    assign {s_err_evt, s_aligned, s_high_err, s_link, s_fault, s_rx_idle, s_tx_idle} = sync_q;

    // Read views; every unlisted bit reads zero.
    always_comb begin
        status_word = PCSSR_RESET_VAL; // RULE14
        status_word[PCSSR_B_TX_IDLE_LATCHED] = state.tx_idle_seen_latched; // RULE1
        status_word[PCSSR_B_RX_IDLE_LATCHED] = state.rx_idle_seen_latched; // RULE2
        status_word[PCSSR_B_TX_IDLE_LIVE] = s_tx_idle; // RULE3
        status_word[PCSSR_B_RX_IDLE_LIVE] = s_rx_idle; // RULE4
        status_word[PCSSR_B_FAULT] = s_fault; // RULE5
        status_word[PCSSR_B_LINK_LATCHED] = state.rx_link_up_latched_low; // RULE6
        status2_word = PCSSR_RESET_VAL; // RULE14
        status2_word[PCSSR_B_LINK_LIVE] = s_link; // RULE6
        status2_word[PCSSR_B_HIGH_ERR_LIVE] = s_high_err; // RULE7
        status2_word[PCSSR_B_ALIGNED_LIVE] = s_aligned; // RULE8
        status2_word[PCSSR_B_HIGH_ERR_LATCHED] = state.high_error_rate_latched; // RULE9
        status2_word[PCSSR_B_ALIGNED_LATCHED] = state.rx_block_aligned_latched_low; // RULE10
        status2_word[ERR_CNT_W-1:0] = state.err_count; // RULE11
    end

    always_comb begin
        logic wr_st;
        logic wr_st2;
        logic [11:0] ridx;
        logic [PCSSR_IRQ_W-1:0] events;
        logic [15:0] wd;
        wr_st = 1'b0;
        wr_st2 = 1'b0;
        ridx = 12'h000;
        events = '0;
        wd = 16'h0000;
        next_state = state;
        // Address and data are taken independently and held until both are present.
        if (s_axi_awvalid && state.awready) begin
            next_state.aw_held = 1'b1;
            next_state.aw_idx = s_axi_awaddr[11:0]; // RULE12
        end
        if (s_axi_wvalid && state.wready) begin
            next_state.w_held = 1'b1;
            next_state.w_data = s_axi_wdata[15:0];
            next_state.w_low_en = s_axi_wstrb[0];
            next_state.w_high_en = s_axi_wstrb[1];
        end
        if (state.aw_held && state.w_held && !state.bvalid) begin
            next_state.aw_held = 1'b0;
            next_state.w_held = 1'b0;
            next_state.bvalid = 1'b1;
            next_state.bresp = PCSSR_RESP_OKAY;
            wd = state.w_data;
            if (!state.w_low_en) begin
                wd[7:0] = 8'hff;
            end
            if (!state.w_high_en) begin
                wd[15:8] = 8'hff;
            end
            case (state.aw_idx)
                PCSSR_IDX_STATUS: wr_st = 1'b1;
                PCSSR_IDX_STATUS2: wr_st2 = 1'b1;
                PCSSR_IDX_IRQ_STATUS: next_state.irq_status = state.irq_status &
                    ~(state.w_low_en ? state.w_data[PCSSR_IRQ_W-1:0] : '0);
                PCSSR_IDX_IRQ_MASK: begin
                    if (state.w_low_en) begin
                        next_state.irq_mask = state.w_data[PCSSR_IRQ_W-1:0];
                    end
                end
                default: next_state.bresp = PCSSR_RESP_SLVERR;
            endcase
        end
        if (state.bvalid && s_axi_bready) begin
            next_state.bvalid = 1'b0;
        end
        // Zero writes release latches; present conditions take priority below.
        if (wr_st && !wd[PCSSR_B_TX_IDLE_LATCHED]) begin
            next_state.tx_idle_seen_latched = 1'b0; // RULE13
        end
        if (wr_st && !wd[PCSSR_B_RX_IDLE_LATCHED]) begin
            next_state.rx_idle_seen_latched = 1'b0; // RULE13
        end
        if (wr_st && !wd[PCSSR_B_LINK_LATCHED]) begin
            next_state.rx_link_up_latched_low = s_link; // RULE13
        end
        if (wr_st2 && !wd[PCSSR_B_HIGH_ERR_LATCHED]) begin
            next_state.high_error_rate_latched = 1'b0; // RULE13
        end
        if (wr_st2 && !wd[PCSSR_B_ALIGNED_LATCHED]) begin
            next_state.rx_block_aligned_latched_low = s_aligned; // RULE13
        end
        if (s_tx_idle) begin
            next_state.tx_idle_seen_latched = 1'b1; // RULE1
        end
        if (s_rx_idle) begin
            next_state.rx_idle_seen_latched = 1'b1; // RULE2
        end
        if (!s_link) begin
            next_state.rx_link_up_latched_low = 1'b0; // RULE6
        end
        if (s_high_err) begin
            next_state.high_error_rate_latched = 1'b1; // RULE9
        end
        if (!s_aligned) begin
            next_state.rx_block_aligned_latched_low = 1'b0; // RULE10
        end
        next_state.err_evt_prev = s_err_evt;
        if (s_err_evt && !state.err_evt_prev) begin
            next_state.err_count = state.err_count + 1'b1; // RULE11
        end
        // Interrupt events: latch sets and the falling edge of the latched-low link bit.
        events[0] = s_tx_idle && !state.tx_idle_seen_latched;
        events[1] = s_rx_idle && !state.rx_idle_seen_latched;
        events[2] = !s_link && state.rx_link_up_latched_low;
        events[3] = s_high_err && !state.high_error_rate_latched;
        next_state.irq_status = next_state.irq_status | events;
        next_state.irq = |(next_state.irq_status & next_state.irq_mask);
        // Read channel: one cycle from address to data.
        if (s_axi_arvalid && state.arready) begin
            ridx = s_axi_araddr[11:0]; // RULE12
            next_state.rvalid = 1'b1;
            next_state.rresp = PCSSR_RESP_OKAY;
            case (ridx)
                PCSSR_IDX_STATUS: next_state.rdata = status_word;
                PCSSR_IDX_STATUS2: next_state.rdata = status2_word;
                PCSSR_IDX_IRQ_STATUS: next_state.rdata = {12'h000, state.irq_status};
                PCSSR_IDX_IRQ_MASK: next_state.rdata = {12'h000, state.irq_mask};
                default: begin
                    next_state.rdata = 16'h0000;
                    next_state.rresp = PCSSR_RESP_SLVERR;
                end
            endcase
        end else if (state.rvalid && s_axi_rready) begin
            next_state.rvalid = 1'b0;
        end
        // Ready flags are registered so that the bus sees flop outputs only.
        next_state.awready = !next_state.aw_held;
        next_state.wready = !next_state.w_held;
        next_state.arready = !next_state.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign s_axi_awready = state.awready;
    assign s_axi_wready = state.wready;
    assign s_axi_bvalid = state.bvalid;
    assign s_axi_bresp = state.bresp;
    assign s_axi_arready = state.arready;
    assign s_axi_rvalid = state.rvalid;
    assign s_axi_rdata = {16'h0000, state.rdata};
    assign s_axi_rresp = state.rresp;
    assign irq = state.irq;

    // Helpers that mirror the cycle in which a write to each status register executes.
    logic wr_dbg;
    logic wr2_dbg;
    assign wr_dbg = state.aw_held && state.w_held && !state.bvalid &&
        state.aw_idx == PCSSR_IDX_STATUS;
    assign wr2_dbg = state.aw_held && state.w_held && !state.bvalid &&
        state.aw_idx == PCSSR_IDX_STATUS2;

    tx_latch_set_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE1
        s_tx_idle |=> state.tx_idle_seen_latched)
        else $error("transmit idle latch did not set");
    rx_latch_set_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE2
        s_rx_idle |=> state.rx_idle_seen_latched)
        else $error("receive idle latch did not set");
    tx_live_read_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE3
        s_axi_arvalid && s_axi_arready && s_axi_araddr[11:0] == PCSSR_IDX_STATUS
        |=> s_axi_rdata[PCSSR_B_TX_IDLE_LIVE] == $past(s_tx_idle))
        else $error("transmit idle live bit wrong");
    rx_live_read_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE4
        s_axi_arvalid && s_axi_arready && s_axi_araddr[11:0] == PCSSR_IDX_STATUS
        |=> s_axi_rdata[PCSSR_B_RX_IDLE_LIVE] == $past(s_rx_idle))
        else $error("receive idle live bit wrong");
    fault_read_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE5
        s_axi_arvalid && s_axi_arready && s_axi_araddr[11:0] == PCSSR_IDX_STATUS
        |=> s_axi_rdata[PCSSR_B_FAULT] == $past(s_fault))
        else $error("fault bit wrong");
    link_live_read_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE6
        s_axi_arvalid && s_axi_arready && s_axi_araddr[11:0] == PCSSR_IDX_STATUS2
        |=> s_axi_rdata[PCSSR_B_LINK_LIVE] == $past(s_link))
        else $error("live link bit wrong");
    high_err_read_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE7
        s_axi_arvalid && s_axi_arready && s_axi_araddr[11:0] == PCSSR_IDX_STATUS2
        |=> s_axi_rdata[PCSSR_B_HIGH_ERR_LIVE] == $past(s_high_err))
        else $error("live high error rate bit wrong");
    aligned_read_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE8
        s_axi_arvalid && s_axi_arready && s_axi_araddr[11:0] == PCSSR_IDX_STATUS2
        |=> s_axi_rdata[PCSSR_B_ALIGNED_LIVE] == $past(s_aligned))
        else $error("live block lock bit wrong");
    link_latch_low_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE6
        !s_link |=> !state.rx_link_up_latched_low)
        else $error("link latch did not drop");
    high_err_latch_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE9
        s_high_err |=> state.high_error_rate_latched)
        else $error("high error rate latch did not set");
    aligned_latch_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE10
        !s_aligned |=> !state.rx_block_aligned_latched_low)
        else $error("block lock latch did not drop");
    err_count_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE11
        s_err_evt && !state.err_evt_prev
        |=> state.err_count == $past(state.err_count) + 1'b1)
        else $error("error counter did not advance");
    count_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE11
        !(s_err_evt && !state.err_evt_prev)
        |=> state.err_count == $past(state.err_count))
        else $error("error counter moved without an event");
    reserved_zero_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE14
        s_axi_rvalid |-> s_axi_rdata[31:12] == 20'h00000)
        else $error("reserved bits not zero");
    latch_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE13
        state.tx_idle_seen_latched && !wr_dbg |=> state.tx_idle_seen_latched)
        else $error("transmit latch lost without clear");
    tx_clear_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE13
        wr_dbg && state.w_high_en && !state.w_data[PCSSR_B_TX_IDLE_LATCHED] && !s_tx_idle
        |=> !state.tx_idle_seen_latched)
        else $error("transmit idle latch not cleared");
    link_reload_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE13
        wr_dbg && state.w_low_en && !state.w_data[PCSSR_B_LINK_LATCHED] && s_link
        |=> state.rx_link_up_latched_low)
        else $error("link latch not restored");
    hi_err_clear_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE13
        wr2_dbg && state.w_low_en && !state.w_data[PCSSR_B_HIGH_ERR_LATCHED] && !s_high_err
        |=> !state.high_error_rate_latched)
        else $error("high error rate latch not cleared");
    aligned_reload_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE13
        wr2_dbg && state.w_low_en && !state.w_data[PCSSR_B_ALIGNED_LATCHED] && s_aligned
        |=> state.rx_block_aligned_latched_low)
        else $error("block lock latch not restored");
    bvalid_drop_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response did not retire");
    rvalid_drop_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read data did not retire");

    write_seen_c: cover property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && s_axi_bready);
    read_seen_c: cover property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && s_axi_rready);
    irq_seen_c: cover property (@(posedge aclk) disable iff (!aresetn) irq);
    count_full_c: cover property (@(posedge aclk) disable iff (!aresetn)
        state.err_count == '1);
endmodule

// >>> shared/pcssr_pkg.sv
// Package with register map, field positions and constants of the coding sublayer status bank.
package pcssr_pkg;
    localparam int unsigned PCSSR_ADDR_W = 16;
    localparam logic [15:0] PCSSR_MMD_SEL = 16'h3000;
    localparam logic [15:0] PCSSR_MMD_MASK = 16'hf000;
    localparam logic [15:0] PCSSR_OFS_STATUS = 16'h3901;
    localparam logic [15:0] PCSSR_OFS_STATUS2 = 16'h3902;
    localparam logic [11:0] PCSSR_IDX_STATUS = 12'h901;
    localparam logic [11:0] PCSSR_IDX_STATUS2 = 12'h902;
    localparam logic [11:0] PCSSR_IDX_IRQ_STATUS = 12'hf00;
    localparam logic [11:0] PCSSR_IDX_IRQ_MASK = 12'hf01;
    localparam int unsigned PCSSR_B_TX_IDLE_LATCHED = 11;
    localparam int unsigned PCSSR_B_RX_IDLE_LATCHED = 10;
    localparam int unsigned PCSSR_B_TX_IDLE_LIVE = 9;
    localparam int unsigned PCSSR_B_RX_IDLE_LIVE = 8;
    localparam int unsigned PCSSR_B_FAULT = 7;
    localparam int unsigned PCSSR_B_LINK_LATCHED = 2;
    localparam int unsigned PCSSR_B_LINK_LIVE = 10;
    localparam int unsigned PCSSR_B_HIGH_ERR_LIVE = 9;
    localparam int unsigned PCSSR_B_ALIGNED_LIVE = 8;
    localparam int unsigned PCSSR_B_HIGH_ERR_LATCHED = 7;
    localparam int unsigned PCSSR_B_ALIGNED_LATCHED = 6;
    localparam int unsigned PCSSR_ERR_CNT_W = 6;
    localparam int unsigned PCSSR_IRQ_W = 4;
    localparam logic [15:0] PCSSR_RESET_VAL = 16'h0000;
    localparam logic [1:0] PCSSR_RESP_OKAY = 2'b00;
    localparam logic [1:0] PCSSR_RESP_SLVERR = 2'b10;
endpackage

// >>> hw/pcssr_sync.sv
// Two flip-flop synchroniser for a vector of asynchronous inputs.
`timescale 1ns/1ps
module pcssr_sync #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Data.
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } pcssr_sync_state_t;

    pcssr_sync_state_t state;
    pcssr_sync_state_t next_state;

    always_comb begin
        next_state = state;
        next_state.stage1 = async_in;
        next_state.stage2 = state.stage1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign sync_out = state.stage2;
endmodule

// >>> tb/pcssr_status_regs_tb.sv
// Self-checking bench for the coding sublayer status register bank.
`timescale 1ns/1ps
module pcssr_status_regs_tb import pcssr_pkg::*;;
    logic aclk;
    logic aresetn;
    logic [15:0] s_axi_awaddr;
    logic s_axi_awvalid;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_wvalid;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready;
    logic [15:0] s_axi_araddr;
    logic s_axi_arvalid;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready;
    logic tx_idle_live;
    logic rx_idle_live;
    logic fault_live;
    logic rx_link_up;
    logic high_error_rate_live;
    logic rx_block_aligned;
    logic error_event;
    logic irq;
    logic [31:0] rd;
    logic [1:0] rs;
    logic [15:0] irq_st;
    logic [15:0] irq_mk;
    logic [5:0] ev [4];
    logic [3:0] nib [3];
    int err_count;
    int samples_checked;
    int cycles;
    localparam int CYCLE_LIMIT = 8000;
    localparam logic [1:0] RSP_OK = PCSSR_RESP_OKAY;

    pcssr_status_regs u_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .tx_idle_live(tx_idle_live), .rx_idle_live(rx_idle_live), .fault_live(fault_live),
        .rx_link_up(rx_link_up), .high_error_rate_live(high_error_rate_live),
        .rx_block_aligned(rx_block_aligned), .error_event(error_event), .irq(irq)
    );

    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask

    task automatic axi_wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic rchk(input string nm, input logic [15:0] a, input logic [31:0] e,
                        input logic [1:0] er);
        axi_rd(a, rd, rs);
        chk(nm, e, rd);
        chk({nm, "_rresp"}, {30'h0, er}, {30'h0, rs});
    endtask

    task automatic wchk(input string nm, input logic [15:0] a, input logic [31:0] d,
                        input logic [1:0] er);
        axi_wr(a, d, rs);
        chk({nm, "_bresp"}, {30'h0, er}, {30'h0, rs});
    endtask

    // Order: tx idle, rx idle, fault, link, high error rate, block aligned.
    task automatic set_cond(input logic [5:0] v);
        @(posedge aclk);
        {tx_idle_live, rx_idle_live, fault_live} <= v[5:3];
        {rx_link_up, high_error_rate_live, rx_block_aligned} <= v[2:0];
        repeat (6) @(posedge aclk);
    endtask

    task automatic pulse_err(input int n);
        repeat (n) begin
            @(posedge aclk);
            error_event <= 1'b1;
            repeat (4) @(posedge aclk);
            error_event <= 1'b0;
            repeat (3) @(posedge aclk);
        end
        repeat (5) @(posedge aclk);
    endtask

    task automatic run_tests();
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        {tx_idle_live, rx_idle_live, fault_live, rx_link_up} = '0;
        {high_error_rate_live, rx_block_aligned, error_event} = '0;
        {err_count, samples_checked} = '0;
        irq_st = {4'h0, PCSSR_IDX_IRQ_STATUS};
        irq_mk = {4'h0, PCSSR_IDX_IRQ_MASK};
        ev = '{6'b100101, 6'b010101, 6'b000001, 6'b000111};
        nib = '{4'h0, 4'h7, 4'hf};
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rchk("status_rst", PCSSR_OFS_STATUS, 32'h0, PCSSR_RESP_OKAY);
        rchk("status2_rst", PCSSR_OFS_STATUS2, 32'h0, PCSSR_RESP_OKAY);
        rchk("irq_mask_rst", irq_mk, 32'h0, PCSSR_RESP_OKAY);
        set_cond(6'b111111);
        rchk("status_on", PCSSR_OFS_STATUS, 32'h0f80, RSP_OK);
        rchk("status2_on", PCSSR_OFS_STATUS2, 32'h0780, RSP_OK);
        wchk("status_w0", PCSSR_OFS_STATUS, 32'h0, PCSSR_RESP_OKAY);
        rchk("status_held", PCSSR_OFS_STATUS, 32'h0f84, PCSSR_RESP_OKAY);
        wchk("status2_w0", PCSSR_OFS_STATUS2, 32'h0, PCSSR_RESP_OKAY);
        rchk("status2_held", PCSSR_OFS_STATUS2, 32'h07c0, PCSSR_RESP_OKAY);
        set_cond(6'b000000);
        set_cond(6'b000101);
        rchk("status_drop", PCSSR_OFS_STATUS, 32'h0c00, PCSSR_RESP_OKAY);
        rchk("status2_drop", PCSSR_OFS_STATUS2, 32'h0580, PCSSR_RESP_OKAY);
        // Low byte only: the link latch reloads while the idle latches keep their ones.
        s_axi_wstrb <= 4'h1;
        wchk("status_strb", PCSSR_OFS_STATUS, 32'h0, PCSSR_RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        rchk("status_strb", PCSSR_OFS_STATUS, 32'h0c04, PCSSR_RESP_OKAY);
        wchk("status_w0b", PCSSR_OFS_STATUS, 32'h0, PCSSR_RESP_OKAY);
        rchk("status_clr", PCSSR_OFS_STATUS, 32'h0004, PCSSR_RESP_OKAY);
        wchk("status_w1", PCSSR_OFS_STATUS, 32'h0000ffff, PCSSR_RESP_OKAY);
        rchk("status_rsvd", PCSSR_OFS_STATUS, 32'h0004, PCSSR_RESP_OKAY);
        wchk("status2_w1", PCSSR_OFS_STATUS2, 32'h0000ffff, PCSSR_RESP_OKAY);
        rchk("status2_rsvd", PCSSR_OFS_STATUS2, 32'h0580, PCSSR_RESP_OKAY);
        wchk("status2_w0b", PCSSR_OFS_STATUS2, 32'h0, PCSSR_RESP_OKAY);
        rchk("status2_clr", PCSSR_OFS_STATUS2, 32'h0540, PCSSR_RESP_OKAY);
        foreach (nib[k]) begin
            rchk("status_nibble", {nib[k], PCSSR_IDX_STATUS}, 32'h0004, RSP_OK);
        end
        rchk("unmapped_rd", 16'h3903, 32'h0, PCSSR_RESP_SLVERR);
        wchk("unmapped_wr", 16'h3903, 32'h0, PCSSR_RESP_SLVERR);
        pulse_err(3);
        rchk("count_3", PCSSR_OFS_STATUS2, 32'h0543, PCSSR_RESP_OKAY);
        rchk("count_keep", PCSSR_OFS_STATUS2, 32'h0543, PCSSR_RESP_OKAY);
        pulse_err(62);
        rchk("count_wrap", PCSSR_OFS_STATUS2, 32'h0541, PCSSR_RESP_OKAY);
        wchk("irq_clr_all", irq_st, 32'h0000000f, PCSSR_RESP_OKAY);
        wchk("irq_mask_all", irq_mk, 32'h0000000f, PCSSR_RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            set_cond(ev[i]);
            set_cond(6'b000101);
            rchk("irq_status", irq_st, 32'h1 << i, PCSSR_RESP_OKAY);
            chk("irq_on", 32'h1, {31'h0, irq});
            wchk("irq_mask_off", irq_mk, 32'hf & ~(32'h1 << i), PCSSR_RESP_OKAY);
            chk("irq_masked", 32'h0, {31'h0, irq});
            wchk("irq_mask_on", irq_mk, 32'h0000000f, PCSSR_RESP_OKAY);
            chk("irq_unmasked", 32'h1, {31'h0, irq});
            // Clear the source latches first so that nothing re-arms the event bit.
            wchk("status_rearm", PCSSR_OFS_STATUS, 32'h0, PCSSR_RESP_OKAY);
            wchk("status2_rearm", PCSSR_OFS_STATUS2, 32'h0, PCSSR_RESP_OKAY);
            wchk("irq_w1c", irq_st, 32'h1 << i, PCSSR_RESP_OKAY);
            repeat (2) @(posedge aclk);
            chk("irq_off", 32'h0, {31'h0, irq});
            rchk("irq_cleared", irq_st, 32'h0, PCSSR_RESP_OKAY);
        end
    endtask

    // The tests race a cycle ceiling, so a hung handshake still reaches the report.
    initial begin
        fork
            run_tests();
            begin
                while (cycles < CYCLE_LIMIT) begin
                    @(posedge aclk);
                    cycles++;
                end
                $display("BAD timeout expected %0d seen %0d", CYCLE_LIMIT, cycles);
                err_count++;
            end
        join_any
        summarize();
    end
endmodule
